// >>> shared/fewc_defines.vh
/*
 * Register indices, control field positions, reset values and timing
 * counts of the flash erase/write controller.
 * Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`ifndef FEWC_DEFINES_VH
`define FEWC_DEFINES_VH

// Register indices; byte address is four times the index
`define FEWC_IDX_CTRL 15'h6270
`define FEWC_IDX_ADDR_LO 15'h6271
`define FEWC_IDX_ADDR_HI 15'h6272
`define FEWC_IDX_WDATA 15'h6273

// Control/status fields
`define FEWC_BIT_BUSY 7
`define FEWC_BIT_FULL 6
`define FEWC_BIT_ABORT 5
`define FEWC_CM_HI 3
`define FEWC_CM_LO 2
`define FEWC_BIT_WRITE 1
`define FEWC_BIT_ERASE 0

// Reset values
`define FEWC_RST_BYTE 8'h00
`define FEWC_RST_CM 2'h1

// Cache modes
`define FEWC_CM_OFF 2'h0
`define FEWC_CM_ON 2'h1
`define FEWC_CM_PREFETCH 2'h2
`define FEWC_CM_REALTIME 2'h3

// Timing
`define FEWC_CLK_KHZ 25000
`define FEWC_CLK_NS 40
`define FEWC_ERASE_MS 20
`define FEWC_ERASE_CYC (`FEWC_ERASE_MS * `FEWC_CLK_KHZ)
`define FEWC_WTO_NS 20000
`define FEWC_WTO_CYC (`FEWC_WTO_NS / `FEWC_CLK_NS)
`define FEWC_PROG_NS 20000
`define FEWC_PROG_CYC (`FEWC_PROG_NS / `FEWC_CLK_NS)
`define FEWC_CM_LAT 4
`define FEWC_BYTES_PER_WORD 3'h4

`endif

// >>> hw/fewc_cache_mode.v
/*
 * Cache mode holder: takes a change request, applies it after a fixed
 * latency, and ignores new requests while one is pending.
 * Assumes the caller gives a one-cycle write strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fewc_defines.vh"

module fewc_cache_mode #(
  parameter [3:0] LAT = `FEWC_CM_LAT
) (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [1:0] wr_mode,
  output reg [1:0] mode_ff,
  output reg pend_ff
);

  reg [1:0] req_ff;
  reg [3:0] cnt_ff;

  //////////////////////////////////////////////////////////////////////
  // Request, wait, apply
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= `FEWC_RST_CM;
      pend_ff <= 1'b0;
      req_ff <= `FEWC_RST_CM;
      cnt_ff <= 4'h0;
    end else if (pend_ff) begin
      if (cnt_ff == 4'h0) begin
        mode_ff <= req_ff;
        pend_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end else if (wr_en) begin
      req_ff <= wr_mode;
      pend_ff <= 1'b1;
      cnt_ff <= LAT - 4'h1;
    end
  end

endmodule // fewc_cache_mode

`default_nettype wire

// >>> hw/fewc_flash_ctrl.v
/*
 * Flash erase/write controller: address pair, write-data port and
 * control/status register on Avalon-MM, page erase and word program
 * sequencer, DMA trigger and CPU stall.
 * Assumes a flash array that sets a page to ones while FLASH_ERASE is
 * high, ANDs FLASH_WORD_DATA into the word while FLASH_PROG is high,
 * and a lock-bit store giving one lock bit per page. The bus master
 * holds each request until waitrequest drops, one wait state later.
 */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fewc_defines.vh"

module fewc_flash_ctrl #(
  parameter [19:0] ERASE_CYC = `FEWC_ERASE_CYC,
  parameter [19:0] WTO_CYC = `FEWC_WTO_CYC,
  parameter [19:0] PROG_CYC = `FEWC_PROG_CYC,
  parameter [3:0] CM_LAT = `FEWC_CM_LAT
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // Avalon-MM slave
  input wire [16:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // DMA trigger
  output reg DMA_REQ,
  // CPU side
  input wire FETCH_FROM_FLASH,
  output wire CPU_STALL,
  output wire [1:0] CACHE_MODE,
  // Lock-bit store
  input wire [127:0] PAGE_LOCK,
  // Flash array
  output reg FLASH_ERASE,
  output reg [6:0] FLASH_ERASE_PAGE,
  output reg FLASH_PROG,
  output reg [15:0] FLASH_WORD_ADDR,
  output reg [31:0] FLASH_WORD_DATA
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ERASE = 2'h1;
  localparam [1:0] ST_FILL = 2'h2;
  localparam [1:0] ST_PROG = 2'h3;

  reg ack_ff;
  reg [7:0] addr_lo_ff;
  reg [7:0] addr_hi_ff;
  reg erase_ff;
  reg write_ff;
  reg full_ff;
  reg abort_ff;
  reg [1:0] state_ff;
  reg [19:0] tmr_ff;
  reg [2:0] cnt_ff;
  reg [31:0] word_ff;
  wire [1:0] cm_cur;
  wire [14:0] idx;
  wire req;
  wire wr_go;
  wire rd_go;
  wire sel_ctrl;
  wire sel_lo;
  wire sel_hi;
  wire sel_wd;
  wire ctl_wr;
  wire busy;
  wire byte_ok;
  wire start_er;
  wire start_wr;
  wire page_locked;
  wire [15:0] addr_nxt;
  wire [7:0] ctrl_rd;
  wire prog_done;
  wire fill_to;

  //////////////////////////////////////////////////////////////////////
  // Helpers
  // Register index match
  function sel_idx;
    input [14:0] got;
    input [14:0] want;
    begin
      sel_idx = (got == want);
    end
  endfunction

  // Page number from the high address byte
  function [6:0] page_of;
    input [7:0] hi;
    begin
      page_of = hi[7:1];
    end
  endfunction

  // Byte value on the 32-bit read bus
  function [31:0] zext8;
    input [7:0] val;
    begin
      zext8 = {24'h000000, val};
    end
  endfunction

  // Shift a byte in from the top, low byte first
  function [31:0] shift_in;
    input [31:0] acc;
    input [7:0] val;
    begin
      shift_in = {val, acc[31:8]};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Bus decode: answer one cycle after the request appears
  assign idx = AVS_ADDRESS[16:2];
  assign req = (AVS_READ | AVS_WRITE) & (AVS_ADDRESS[1:0] == 2'h0);
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
  assign wr_go = AVS_WRITE & ack_ff & AVS_BYTEENABLE[0];
  assign rd_go = AVS_READ & ~ack_ff;
  assign sel_ctrl = req & sel_idx(idx, `FEWC_IDX_CTRL);
  assign sel_lo = req & sel_idx(idx, `FEWC_IDX_ADDR_LO);
  assign sel_hi = req & sel_idx(idx, `FEWC_IDX_ADDR_HI);
  assign sel_wd = req & sel_idx(idx, `FEWC_IDX_WDATA);
  assign ctl_wr = wr_go & sel_ctrl;

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status and start conditions
  assign busy = erase_ff | write_ff;
  assign CPU_STALL = busy & FETCH_FROM_FLASH;
  assign CACHE_MODE = cm_cur;
  assign page_locked = PAGE_LOCK[page_of(addr_hi_ff)];
  assign prog_done = (state_ff == ST_PROG) & (tmr_ff == 20'h00000);
  assign fill_to = (tmr_ff == WTO_CYC);
  assign addr_nxt = {addr_hi_ff, addr_lo_ff} + 16'h0001;
  // Data port takes a byte only in write mode and with room left
  assign byte_ok = wr_go & sel_wd & write_ff & ~full_ff;
  // A new start is refused while either operation runs
  assign start_er = ctl_wr & AVS_WRITEDATA[`FEWC_BIT_ERASE]
    & ~erase_ff & ~write_ff;
  assign start_wr = ctl_wr & AVS_WRITEDATA[`FEWC_BIT_WRITE]
    & ~write_ff & ~erase_ff;
  assign ctrl_rd = {busy, full_ff, abort_ff, 1'b0, cm_cur, write_ff,
    erase_ff};

  //////////////////////////////////////////////////////////////////////
  // Read data
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (rd_go) begin
      if (sel_ctrl) begin
        AVS_READDATA <= zext8(ctrl_rd);
      end else if (sel_lo) begin
        AVS_READDATA <= zext8(addr_lo_ff);
      end else if (sel_hi) begin
        AVS_READDATA <= zext8(addr_hi_ff);
      end else begin
        AVS_READDATA <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Cache mode
  fewc_cache_mode #(
    .LAT(CM_LAT)
  ) u_cache_mode (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .wr_en(ctl_wr),
    .wr_mode(AVS_WRITEDATA[`FEWC_CM_HI:`FEWC_CM_LO]),
    .mode_ff(cm_cur),
    .pend_ff()
  );

  //////////////////////////////////////////////////////////////////////
  // Address pair
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_lo_ff <= `FEWC_RST_BYTE;
      addr_hi_ff <= `FEWC_RST_BYTE;
    end else begin
      if (prog_done) begin
        {addr_hi_ff, addr_lo_ff} <= addr_nxt;
      end else if (!busy) begin
        if (wr_go && sel_lo) begin
          addr_lo_ff <= AVS_WRITEDATA[7:0];
        end
        if (wr_go && sel_hi) begin
          addr_hi_ff <= AVS_WRITEDATA[7:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Erase and write sequencer
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      erase_ff <= 1'b0;
      write_ff <= 1'b0;
      full_ff <= 1'b0;
      abort_ff <= 1'b0;
      tmr_ff <= 20'h00000;
      cnt_ff <= 3'h0;
      word_ff <= 32'h0000_0000;
      DMA_REQ <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_ERASE_PAGE <= 7'h00;
      FLASH_PROG <= 1'b0;
      FLASH_WORD_ADDR <= 16'h0000;
      FLASH_WORD_DATA <= 32'hFFFF_FFFF;
    end else begin
      DMA_REQ <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start_er || start_wr) begin
            abort_ff <= 1'b0;
            full_ff <= 1'b0;
            cnt_ff <= 3'h0;
            if (page_locked) begin
              abort_ff <= 1'b1;
            end else if (start_er) begin
              erase_ff <= 1'b1;
              write_ff <= start_wr;
              state_ff <= ST_ERASE;
              tmr_ff <= ERASE_CYC - 20'h00001;
              FLASH_ERASE <= 1'b1;
              FLASH_ERASE_PAGE <= page_of(addr_hi_ff);
            end else begin
              write_ff <= 1'b1;
              state_ff <= ST_FILL;
              tmr_ff <= 20'h00000;
              DMA_REQ <= 1'b1;
            end
          end
        end
        ST_ERASE: begin
          if (tmr_ff == 20'h00000) begin
            erase_ff <= 1'b0;
            FLASH_ERASE <= 1'b0;
            if (write_ff) begin
              state_ff <= ST_FILL;
              DMA_REQ <= 1'b1;
            end else begin
              state_ff <= ST_IDLE;
            end
          end else begin
            tmr_ff <= tmr_ff - 20'h00001;
          end
        end
        ST_FILL: begin
          if (byte_ok) begin
            // Least significant byte arrives first
            word_ff <= shift_in(word_ff, AVS_WRITEDATA[7:0]);
            tmr_ff <= 20'h00000;
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == `FEWC_BYTES_PER_WORD - 3'h1) begin
              if (page_locked) begin
                abort_ff <= 1'b1;
                write_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end else begin
                full_ff <= 1'b1;
                state_ff <= ST_PROG;
                tmr_ff <= PROG_CYC - 20'h00001;
                FLASH_PROG <= 1'b1;
                FLASH_WORD_ADDR <= {addr_hi_ff, addr_lo_ff};
                // Ones leave array bits alone
                FLASH_WORD_DATA <= shift_in(word_ff,
                  AVS_WRITEDATA[7:0]);
              end
            end else begin
              DMA_REQ <= 1'b1;
            end
          end else if (fill_to) begin
            write_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end else begin
            tmr_ff <= tmr_ff + 20'h00001;
          end
        end
        ST_PROG: begin
          if (tmr_ff == 20'h00000) begin
            FLASH_PROG <= 1'b0;
            FLASH_WORD_DATA <= 32'hFFFF_FFFF;
            full_ff <= 1'b0;
            cnt_ff <= 3'h0;
            state_ff <= ST_FILL;
            DMA_REQ <= 1'b1;
          end else begin
            tmr_ff <= tmr_ff - 20'h00001;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // fewc_flash_ctrl

`default_nettype wire

// >>> tb/fewc_flash_monitor.sv
/*
 * Checker for the flash erase/write controller top ports.
 * Assumes it is bound onto fewc_flash_ctrl and shares its clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fewc_flash_monitor #(
  parameter [19:0] ERASE_CYC = 20'h14,
  parameter [19:0] PROG_CYC = 20'h4
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // Bus and CPU side
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic DMA_REQ,
  input wire logic FETCH_FROM_FLASH,
  input wire logic CPU_STALL,
  // Flash side
  input wire logic [127:0] PAGE_LOCK,
  input wire logic FLASH_ERASE,
  input wire logic [6:0] FLASH_ERASE_PAGE,
  input wire logic FLASH_PROG,
  input wire logic [15:0] FLASH_WORD_ADDR,
  input wire logic [31:0] FLASH_WORD_DATA
);
  logic [19:0] ecnt_ff;
  logic [19:0] pcnt_ff;

  ////////////////////////////////////////////////////////////////////////
  // Length counters
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ecnt_ff <= 20'h0;
      pcnt_ff <= 20'h0;
    end else begin
      ecnt_ff <= FLASH_ERASE ? ecnt_ff + 20'h1 : 20'h0;
      pcnt_ff <= FLASH_PROG ? pcnt_ff + 20'h1 : 20'h0;
    end
  end

  default clocking dcb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  ////////////////////////////////////////////////////////////////////////
  // Properties
  AST_ERASE_LEN: assert property ($fell(FLASH_ERASE) |->
    ecnt_ff >= ERASE_CYC && ecnt_ff <= ERASE_CYC + 20'h1)
    else $error("erase length off");
  AST_PROG_LEN: assert property ($fell(FLASH_PROG) |->
    pcnt_ff == PROG_CYC) else $error("program length off");
  AST_NO_OVERLAP: assert property (FLASH_ERASE |-> !FLASH_PROG)
    else $error("program during erase");
  AST_PAGE_HOLD: assert property (FLASH_ERASE && $past(FLASH_ERASE) |->
    $stable(FLASH_ERASE_PAGE)) else $error("erase page moved");
  AST_ERASE_LOCK: assert property ($rose(FLASH_ERASE) |->
    !PAGE_LOCK[FLASH_ERASE_PAGE]) else $error("locked page erased");
  AST_PROG_LOCK: assert property ($rose(FLASH_PROG) |->
    !PAGE_LOCK[FLASH_WORD_ADDR[15:9]]) else $error("locked page written");
  AST_WORD_HOLD: assert property (FLASH_PROG && $past(FLASH_PROG) |->
    $stable(FLASH_WORD_ADDR) && $stable(FLASH_WORD_DATA))
    else $error("word moved in program");
  AST_STALL: assert property ((FLASH_ERASE || FLASH_PROG) &&
    FETCH_FROM_FLASH |-> CPU_STALL) else $error("cpu not stalled");
  AST_DMA_PULSE: assert property (DMA_REQ |=> !DMA_REQ)
    else $error("dma request too long");
  AST_DMA_PROG: assert property (FLASH_PROG |-> !DMA_REQ)
    else $error("dma request while programming");
  AST_BUS_WAIT: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bus wait wrong");
endmodule // fewc_flash_monitor

bind fewc_flash_ctrl fewc_flash_monitor #(.ERASE_CYC(ERASE_CYC),
  .PROG_CYC(PROG_CYC)) u_mon (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .DMA_REQ(DMA_REQ),
  .FETCH_FROM_FLASH(FETCH_FROM_FLASH), .CPU_STALL(CPU_STALL),
  .PAGE_LOCK(PAGE_LOCK), .FLASH_ERASE(FLASH_ERASE),
  .FLASH_ERASE_PAGE(FLASH_ERASE_PAGE), .FLASH_PROG(FLASH_PROG),
  .FLASH_WORD_ADDR(FLASH_WORD_ADDR), .FLASH_WORD_DATA(FLASH_WORD_DATA));

`default_nettype wire

// >>> tb/fewc_flash_array.sv
/*
 * Behavioural flash array with lock-bit store.
 * Assumes erase and program strobes from the controller; unwritten words
 * read as zero so an erase shows.
 */
`timescale 1ns/1ps
`default_nettype none

module fewc_flash_array (
  // Controller side
  input wire logic clk,
  input wire logic erase,
  input wire logic [6:0] page,
  input wire logic prog,
  input wire logic [15:0] addr,
  input wire logic [31:0] data,
  // Lock store
  input wire logic [127:0] lock_cfg,
  output logic [127:0] page_lock
);
  logic [31:0] mem [int];
  logic prog_d;

  assign page_lock = lock_cfg;

  function automatic logic [31:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction

  always @(posedge clk) begin
    prog_d <= prog;
    if (erase) begin
      for (int i = 0; i < 512; i++) mem[{page, i[8:0]}] = 32'hFFFFFFFF;
    end
    if (prog && !prog_d) mem[addr] = rd(addr) & data;
  end
endmodule // fewc_flash_array

`default_nettype wire

// >>> tb/fewc_testbench.sv
/*
 * Self-checking bench: register access, cache modes, erase, lock abort,
 * DMA and CPU word programming.
 * Assumes short erase, timeout and program counts set below.
 */
`include "fewc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, arst_n, rd_en, wr_en, fetch, wait_r, dma, stall, fe, fp;
  logic [16:0] adr;
  logic [31:0] wdat, rdat, fdat, rv;
  logic [127:0] lock_cfg, lock;
  logic [1:0] cm;
  logic [3:0] ben;
  logic [6:0] fpg;
  logic [15:0] fadr;
  int error_cnt = 0, total_checks = 0, dma_cnt = 0, cyc = 0, taken = 0;

  fewc_flash_ctrl #(.ERASE_CYC(20'h14), .WTO_CYC(20'h1E), .PROG_CYC(20'h4))
  DUT (.SYS_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .DMA_REQ(dma),
    .FETCH_FROM_FLASH(fetch), .CPU_STALL(stall), .CACHE_MODE(cm),
    .PAGE_LOCK(lock), .FLASH_ERASE(fe), .FLASH_ERASE_PAGE(fpg),
    .FLASH_PROG(fp), .FLASH_WORD_ADDR(fadr), .FLASH_WORD_DATA(fdat));
  fewc_flash_array FA (.clk(clk), .erase(fe), .page(fpg), .prog(fp),
    .addr(fadr), .data(fdat), .lock_cfg(lock_cfg), .page_lock(lock));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic bus(input bit we, input [14:0] idx, input [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'h0};
    wr_en <= we;
    rd_en <= !we;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wait_r !== 1'b0);
    rv = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input [14:0] idx, input [7:0] e);
    bus(1'b0, idx, 8'h0);
    chk(n, {24'h0, e}, rv);
  endtask

  task automatic wait_idle;
    for (int k = 0; k < 100; k++) begin
      bus(1'b0, `FEWC_IDX_CTRL, 8'h0);
      if (rv[7] === 1'b0) break;
    end
    chk("busy_end", 32'h0, {31'h0, rv[7]});
  endtask

  // Bus master in the role of the DMA channel
  task automatic dma_word(input [31:0] w);
    for (int i = 0; i < 4; i++) begin
      while (dma_cnt <= taken) @(posedge clk);
      taken++;
      bus(1'b1, `FEWC_IDX_WDATA, w[8*i +: 8]);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma === 1'b1) dma_cnt <= dma_cnt + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    arst_n = 0;
    adr = 0;
    rd_en = 0;
    wr_en = 0;
    wdat = 0;
    fetch = 1;
    ben = 4'hF;
    lock_cfg = 128'h20;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("ctrl", `FEWC_IDX_CTRL, 8'h04);
    rd_chk("addr_hi", `FEWC_IDX_ADDR_HI, 8'h00);
    rd_chk("addr_lo", `FEWC_IDX_ADDR_LO, 8'h00);
    rd_chk("wdata", `FEWC_IDX_WDATA, 8'h00);
    bus(1'b1, 15'h6274, 8'hFF);
    rd_chk("unmapped", 15'h6274, 8'h00);
    // Write with the low byte lane off is dropped
    ben <= 4'hE;
    bus(1'b1, `FEWC_IDX_ADDR_LO, 8'h55);
    ben <= 4'hF;
    rd_chk("be_off", `FEWC_IDX_ADDR_LO, 8'h00);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `FEWC_IDX_CTRL, {4'h0, m[1:0], 2'h0});
      repeat (8) @(posedge clk);
      rd_chk("cm", `FEWC_IDX_CTRL, {4'h0, m[1:0], 2'h0});
      chk("cm_pin", {30'h0, m[1:0]}, {30'h0, cm});
    end
    bus(1'b1, `FEWC_IDX_CTRL, 8'h08);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h04);
    repeat (8) @(posedge clk);
    rd_chk("cm_pend", `FEWC_IDX_CTRL, 8'h08);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h04);
    repeat (8) @(posedge clk);
    // Erase page 3, low bit of high byte set
    bus(1'b1, `FEWC_IDX_ADDR_HI, 8'h07);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h05);
    rd_chk("erase_busy", `FEWC_IDX_CTRL, 8'h85);
    chk("stall", 32'h1, {31'h0, stall});
    fetch <= 1'b0;
    @(posedge clk);
    chk("no_stall", 32'h0, {31'h0, stall});
    fetch <= 1'b1;
    bus(1'b1, `FEWC_IDX_CTRL, 8'h06);
    wait_idle();
    rd_chk("erase_done", `FEWC_IDX_CTRL, 8'h04);
    chk("dma_none", 0, dma_cnt);
    chk("erased_lo", 32'hFFFFFFFF, FA.rd(16'h0600));
    chk("erased_hi", 32'hFFFFFFFF, FA.rd(16'h07FF));
    chk("page2", 32'h0, FA.rd(16'h05FF));
    // Locked page
    bus(1'b1, `FEWC_IDX_ADDR_HI, 8'h0A);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h05);
    rd_chk("abort", `FEWC_IDX_CTRL, 8'h24);
    // Erase and two words by DMA
    bus(1'b1, `FEWC_IDX_ADDR_HI, 8'h08);
    bus(1'b1, `FEWC_IDX_ADDR_LO, 8'h0A);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h07);
    rd_chk("both_busy", `FEWC_IDX_CTRL, 8'h87);
    chk("dma_wait", 0, dma_cnt);
    dma_word(32'h12345678);
    dma_word(32'hFFFF00FF);
    wait_idle();
    rd_chk("timeout", `FEWC_IDX_CTRL, 8'h04);
    chk("dma_cnt", 9, dma_cnt);
    chk("word0", 32'h12345678, FA.rd(16'h080A));
    rd_chk("addr_inc", `FEWC_IDX_ADDR_LO, 8'h0C);
    // CPU write over a programmed word
    bus(1'b1, `FEWC_IDX_ADDR_LO, 8'h0B);
    bus(1'b1, `FEWC_IDX_CTRL, 8'h06);
    for (int i = 0; i < 4; i++) bus(1'b1, `FEWC_IDX_WDATA, i == 3 ? 8'hF0 : 8'hFF);
    rd_chk("full", `FEWC_IDX_CTRL, 8'hC6);
    wait_idle();
    chk("word1", 32'hF0FF00FF, FA.rd(16'h080B));
    // Page locked between start and the last byte of a word
    bus(1'b1, `FEWC_IDX_CTRL, 8'h06);
    lock_cfg <= 128'h30;
    for (int i = 0; i < 4; i++) bus(1'b1, `FEWC_IDX_WDATA, 8'h00);
    rd_chk("word_abort", `FEWC_IDX_CTRL, 8'h24);
    chk("word_locked", 32'hFFFFFFFF, FA.rd(16'h080C));
    close_out();
  end
endmodule // testbench

`default_nettype wire
